// ### core/dcsp_regs.svh
// Constants for the chained serial port: frame lengths, field positions, addresses, reset values.
`ifndef DCSP_REGS_SVH
`define DCSP_REGS_SVH

// Per-device share of a chained frame, without and with the check byte
`define DCSP_LEN_PLAIN    5'd16
`define DCSP_LEN_CHECK    5'd24
// Free-running link bit counter wraps here; a multiple of both lengths
`define DCSP_CNT_MOD      9'd240
`define DCSP_CNT_LAST     8'hEF

// Command word fields, counted inside the 16 command bits
`define DCSP_CMD_ADDR_HI  13
`define DCSP_CMD_ADDR_LO  9
`define DCSP_CMD_WR_BIT   8
`define DCSP_CMD_DATA_HI  7
`define DCSP_CMD_DATA_LO  0

// Register addresses served from live state rather than storage
`define DCSP_ADDR_INPUTS  5'h00
`define DCSP_ADDR_FAULTS  5'h01

// Fault reset value and fixed check byte
`define DCSP_FAULT_RST    8'h60
`define DCSP_CHECK_BYTE   8'h00

`endif

// ### core/dcsp_pkg.sv
// Types shared by the chained serial port design.
package dcsp_pkg;

  // Core-side frame handling sequence
  typedef enum logic [1:0] {
    DCSP_ST_IDLE,
    DCSP_ST_CHECK,
    DCSP_ST_READ,
    DCSP_ST_BUILD
  } dcsp_state_t;

  typedef logic [4:0] dcsp_addr_t;
  typedef logic [7:0] dcsp_byte_t;

endpackage

// ### core/dcsp_mem.sv
// Small register store with synchronous write and registered read data.
`timescale 1ns/1ps
module dcsp_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output      logic [DW-1:0] rdata
);

  logic [DW-1:0] store_q [0:(1<<AW)-1];

  // Storage itself needs no reset; contents are defined by the first write
  always_ff @(posedge clk) begin
    if (we) begin
      store_q[waddr] <= wdata;
    end
  end

  // Read data leaves through a register
  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= store_q[raddr];
    end
  end

endmodule

// ### core/dcsp_fifo2.sv
// Small shifting buffer whose head entry is always a register.
`timescale 1ns/1ps
module dcsp_fifo2 #(
  parameter int W     = 13,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  logic [W-1:0] data_q  [0:DEPTH-1];
  logic [DEPTH-1:0] full_q;
  wire          pop  = full_q[0] & out_ready;
  wire          push = in_valid & in_ready;
  // Neighbour flags padded at both ends so no slot looks outside the array
  wire [DEPTH:0] full_above = {1'b0, full_q};
  wire [DEPTH:0] full_below = {full_q, 1'b1};

  // Ready while the tail slot is free or the head leaves this cycle
  assign in_ready  = ~full_q[DEPTH-1] | pop;
  assign out_valid = full_q[0];
  assign out_data  = data_q[0];

  // Entries shift toward the head on a pop; a push lands in the first free slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        data_q[i] <= '0;
      end
    end else begin
      if (pop) begin
        for (int i = 0; i < DEPTH-1; i++) begin
          data_q[i] <= data_q[i+1];
        end
      end
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          full_q[i] <= full_above[i+1];
        end
        if (push && (pop ? (full_q[i] & ~full_above[i+1]) : (~full_q[i] & full_below[i]))) begin
          full_q[i] <= 1'b1;
          data_q[i] <= in_data;
        end
      end
    end
  end

endmodule

// ### core/dcsp_top.sv
// Chained serial port: link shift logic on the serial clock, command handling on the core clock.
// Summary of operation
// - chain-select pin high enables chained mode; commands pass through to later devices.
// - chained mode never clears latched faults on access, whatever the clear setting.
// - after a write, send input-state byte high channel first, then fault byte.
// - write after a read sends input-state byte, then the prior-read register value.
// - read after a read sends input-state byte, then the earlier-addressed register value.
// - each device shifts out its previous response while commands pass downstream.
// - the two top command bits are ignored in chained mode.
// - per-device share is 16 bits, or 24 with the check byte.
// - a clock count not a multiple of the share flags an error, command ignored.
// - sample input on rising clock, update output on falling; output off when deselected.
`timescale 1ns/1ps
`include "dcsp_regs.svh"
module dcsp_top #(
  parameter int AW = 5
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output      logic       sdo_o,
  output      logic       sdo_oe_o,
  input  wire logic       chain_select,
  input  wire logic       check_code_enable_pin,
  input  wire logic       fault_clear_on_access,
  input  wire logic [7:0] input_state_bits,
  input  wire logic [7:0] fault_event,
  input  wire logic       clock_count_error_clr,
  output      logic       clock_count_error,
  output      logic [7:0] fault_summary_bits,
  output      logic       wr_valid,
  input  wire logic       wr_ready,
  output      logic [4:0] wr_addr,
  output      logic [7:0] wr_data
);

  // Distance from frame start to the present count, modulo the counter wrap
  function automatic logic [7:0] wrap_diff(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = (a >= b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + `DCSP_CNT_MOD - {1'b0, b});
    return t[7:0];
  endfunction

  // Reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pin synchronisers on the core clock
  logic       cs_meta_q;
  logic       cs_s_q;
  logic       cs_d_q;
  logic       chain_meta_q;
  logic       chain_q;
  logic       chk_meta_q;
  logic       chk_q;
  logic [7:0] in_meta_q;
  logic [7:0] in_q;
  logic [7:0] flt_meta_q;
  logic [7:0] flt_q;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_meta_q    <= 1'b1;
      cs_s_q       <= 1'b1;
      cs_d_q       <= 1'b1;
      chain_meta_q <= 1'b0;
      chain_q      <= 1'b0;
      chk_meta_q   <= 1'b0;
      chk_q        <= 1'b0;
      in_meta_q    <= 8'h00;
      in_q         <= 8'h00;
      flt_meta_q   <= 8'h00;
      flt_q        <= 8'h00;
    end else begin
      cs_meta_q    <= cs_n;
      cs_s_q       <= cs_meta_q;
      cs_d_q       <= cs_s_q;
      chain_meta_q <= chain_select;
      chain_q      <= chain_meta_q;
      chk_meta_q   <= check_code_enable_pin;
      chk_q        <= chk_meta_q;
      in_meta_q    <= input_state_bits;
      in_q         <= in_meta_q;
      flt_meta_q   <= fault_event;
      flt_q        <= flt_meta_q;
    end
  end

  // Link side: check-pin copy on the serial clock
  logic lchk_meta_q;
  logic lchk_q;
  logic [7:0]  cnt_q;
  logic [23:0] rx_q;
  logic [7:0]  start_q;
  logic [23:0] resp_q;
  logic        sdo_q;
  logic        started_q;

  always_ff @(posedge sclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lchk_meta_q <= 1'b0;
      lchk_q      <= 1'b0;
    end else begin
      lchk_meta_q <= check_code_enable_pin;
      lchk_q      <= lchk_meta_q;
    end
  end

  // Rising edge: count clocks and shift in; the counter never resets per frame,
  // so the core can read the whole frame's count after deselect
  always_ff @(posedge sclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= 8'h00;
      rx_q  <= 24'h000000;
    end else if (!cs_n) begin
      cnt_q <= (cnt_q == `DCSP_CNT_LAST) ? 8'h00 : cnt_q + 8'h01;
      rx_q  <= {rx_q[22:0], sdi};
    end
  end

  // Output tap: own response first, then the bits received one share earlier
  wire [7:0] link_idx  = wrap_diff(cnt_q, start_q);
  wire [4:0] link_len  = lchk_q ? `DCSP_LEN_CHECK : `DCSP_LEN_PLAIN;
  wire       pass_bit  = lchk_q ? rx_q[23] : rx_q[15];
  wire       own_bit   = resp_q[5'd23 - link_idx[4:0]];
  wire       next_bit  = (link_idx < {3'b000, link_len}) ? own_bit : pass_bit;

  // Falling edge updates the output
  always_ff @(negedge sclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= next_bit;
    end
  end

  // First bit appears at select, before any falling edge, so it comes from the response word
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // Output enable follows select directly so release is immediate
  assign sdo_o    = started_q ? sdo_q : resp_q[23];
  assign sdo_oe_o = ~cs_n;

  // Core side: frame check and command decode
  dcsp_pkg::dcsp_state_t state_q;
  dcsp_pkg::dcsp_addr_t  rd_addr_q;
  logic       prev_read_q;
  logic [7:0] faults_q;
  logic       cce_q;
  logic       pend_q;
  logic [4:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic       push_ready;
  logic [7:0] mem_rdata;

  // Count and command fields are stable here: the serial clock idles while deselected
  wire        cs_rise    = cs_s_q & ~cs_d_q;
  wire [7:0]  frame_bits = wrap_diff(cnt_q, start_q);
  wire [4:0]  share      = chk_q ? `DCSP_LEN_CHECK : `DCSP_LEN_PLAIN;
  wire        frame_ok   = (frame_bits % {3'b000, share}) == 8'h00;
  wire        no_clocks  = frame_bits == 8'h00;
  wire [15:0] cmd        = chk_q ? rx_q[23:8] : rx_q[15:0];
  wire [4:0]  cmd_addr   = cmd[`DCSP_CMD_ADDR_HI:`DCSP_CMD_ADDR_LO];
  wire        cmd_wr     = cmd[`DCSP_CMD_WR_BIT];
  wire [7:0]  cmd_data   = cmd[`DCSP_CMD_DATA_HI:`DCSP_CMD_DATA_LO];
  wire        in_check   = state_q == dcsp_pkg::DCSP_ST_CHECK;
  wire        wr_stall   = in_check & cmd_wr & pend_q;
  wire        take_cmd   = in_check & chain_q & ~no_clocks & frame_ok & ~wr_stall;
  wire        live_addr  = (cmd_addr == `DCSP_ADDR_INPUTS) | (cmd_addr == `DCSP_ADDR_FAULTS);
  wire        mem_we     = take_cmd & cmd_wr & ~live_addr;
  wire        cce_set    = in_check & chain_q & ~no_clocks & ~frame_ok;

  // Fault clearing on access never fires: it needs chained mode off, take_cmd needs it on
  wire        acc_clear  = take_cmd & ~chain_q &
                           (~fault_clear_on_access | (~cmd_wr & (cmd_addr == `DCSP_ADDR_FAULTS)));

  // Second response byte: fault byte after a write, register value after a read
  wire [7:0]  rd_value   = (rd_addr_q == `DCSP_ADDR_INPUTS) ? in_q :
                           (rd_addr_q == `DCSP_ADDR_FAULTS) ? faults_q : mem_rdata;
  wire [7:0]  second     = prev_read_q ? rd_value : faults_q;

  // Sequence: wait deselect, check and decode, read, build the next response
  // Reset starts with an empty check, so the input pins clear their synchroniser before the first build
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= dcsp_pkg::DCSP_ST_CHECK;
    end else begin
      case (state_q)
        dcsp_pkg::DCSP_ST_IDLE: begin
          if (cs_rise) begin
            state_q <= dcsp_pkg::DCSP_ST_CHECK;
          end
        end
        dcsp_pkg::DCSP_ST_CHECK: begin
          if (!wr_stall) begin
            state_q <= dcsp_pkg::DCSP_ST_READ;
          end
        end
        dcsp_pkg::DCSP_ST_READ:  state_q <= dcsp_pkg::DCSP_ST_BUILD;
        dcsp_pkg::DCSP_ST_BUILD: state_q <= dcsp_pkg::DCSP_ST_IDLE;
        default:                 state_q <= dcsp_pkg::DCSP_ST_IDLE;
      endcase
    end
  end

  // Frame start count and the accepted command's read/write history
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_q     <= 8'h00;
      prev_read_q <= 1'b0;
      rd_addr_q   <= 5'h00;
    end else begin
      if (in_check && !wr_stall) begin
        start_q <= cnt_q;
      end
      if (take_cmd) begin
        prev_read_q <= ~cmd_wr;
        if (!cmd_wr) begin
          rd_addr_q <= cmd_addr;
        end
      end
    end
  end

  // Next response word; held still through the frame that shifts it out
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      resp_q <= 24'h000000;
    end else if (state_q == dcsp_pkg::DCSP_ST_BUILD) begin
      resp_q <= {in_q, second, `DCSP_CHECK_BYTE};
    end
  end

  // Latched faults and clock-count flag; a new event beats a clear
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      faults_q <= `DCSP_FAULT_RST;
      cce_q    <= 1'b0;
    end else begin
      faults_q <= (acc_clear ? 8'h00 : faults_q) | flt_q;
      cce_q    <= (cce_q & ~clock_count_error_clr) | cce_set;
    end
  end

  // Accepted writes wait here until the buffer takes them; a write arriving while one still waits stalls decode
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q      <= 1'b0;
      pend_addr_q <= 5'h00;
      pend_data_q <= 8'h00;
    end else if (take_cmd && cmd_wr) begin
      pend_q      <= 1'b1;
      pend_addr_q <= cmd_addr;
      pend_data_q <= cmd_data;
    end else if (push_ready) begin
      pend_q      <= 1'b0;
    end
  end

  assign clock_count_error  = cce_q;
  assign fault_summary_bits = faults_q;

  dcsp_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clk   (core_clk),
    .we    (mem_we),
    .waddr (cmd_addr),
    .wdata (cmd_data),
    .re    (state_q == dcsp_pkg::DCSP_ST_READ),
    .raddr (rd_addr_q),
    .rdata (mem_rdata)
  );

  dcsp_fifo2 #(
    .W     (13),
    .DEPTH (2)
  ) u_wr_buf (
    .clk       (core_clk),
    .rst_n     (rst_n_q),
    .in_valid  (pend_q),
    .in_ready  (push_ready),
    .in_data   ({pend_addr_q, pend_data_q}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

endmodule

// ### tb/dcsp_top_asserts.sv
// Concurrent checks on the chained serial port top-level ports.
`timescale 1ns/1ps
module dcsp_top_asserts (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       cs_n,
  input wire logic       sdo_oe_o,
  input wire logic       chain_select,
  input wire logic [7:0] fault_event,
  input wire logic [7:0] fault_summary_bits,
  input wire logic       clock_count_error_clr,
  input wire logic       clock_count_error,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Write offered but not yet taken downstream
  sequence s_wr_stall;
    wr_valid && !wr_ready;
  endsequence
  // Select seen high on two samples, so the frame is closed
  sequence s_closed;
    $past(cs_n) && cs_n;
  endsequence
  a_oe_follows_select: assert property (sdo_oe_o == !cs_n)
    else $error("sdo enable differs from select");
  a_wr_held_stall: assert property (s_wr_stall |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("stalled write changed or dropped");
  a_write_chained_only: assert property ($rose(wr_valid) |-> s_closed ##0 chain_select)
    else $error("write offered outside a closed chained frame");
  // Chained mode high now and three samples back before fault bits are judged
  a_fault_never_cleared: assert property (chain_select && $past(chain_select, 3)
    |-> (fault_summary_bits & $past(fault_summary_bits)) == $past(fault_summary_bits))
    else $error("latched fault bit cleared in chained mode");
  a_fault_event_sets: assert property (fault_event[3] |-> ##[1:4] fault_summary_bits[3])
    else $error("fault event not latched");
  a_reset_state: assert property ($rose(resetn) |-> fault_summary_bits == 8'h60 && !wr_valid && !clock_count_error)
    else $error("wrong state at reset release");
  a_err_sticky: assert property (clock_count_error && !clock_count_error_clr && !$past(clock_count_error_clr)
    |=> clock_count_error)
    else $error("clock count flag dropped without clear");
  a_err_after_frame: assert property ($rose(clock_count_error) |-> s_closed)
    else $error("clock count flag set inside a frame");
  a_err_clears: assert property (clock_count_error_clr [*2] |-> ##[0:2] !clock_count_error)
    else $error("clock count flag not cleared");
endmodule

bind dcsp_top dcsp_top_asserts dcsp_top_asserts_i (
  .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sdo_oe_o(sdo_oe_o),
  .chain_select(chain_select), .fault_event(fault_event), .fault_summary_bits(fault_summary_bits),
  .clock_count_error_clr(clock_count_error_clr), .clock_count_error(clock_count_error),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
);

// ### tb/dcsp_host_model.sv
// Behavioural serial bus controller driving the chained port.
`timescale 1ns/1ps
module dcsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // Idle bus: select high, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // One frame MSB first at 12 ns per bit; a bit read while undriven counts as unknown
  task automatic frame(input int n, input logic [47:0] cmd, output logic [47:0] resp);
    resp = '0;
    cs_n = 1'b0;
    #6;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = cmd[i];
      #6 sclk = 1'b1;
      resp = {resp[46:0], sdo_oe ? sdo : 1'bx};
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    // Released line must not keep showing its last level
    sdi = ~sdi;
  endtask
endmodule

// ### tb/dcsp_top_tb.sv
// Self-checking bench for the chained serial port.
`timescale 1ns/1ps
module dcsp_top_tb;
  logic        core_clk, resetn, sclk, cs_n, sdi, sdo_o, sdo_oe_o;
  logic        chain_select, check_code_enable_pin, fault_clear_on_access;
  logic        clock_count_error_clr, clock_count_error, wr_valid, wr_ready;
  logic [7:0]  input_state_bits, fault_event, fault_summary_bits, wr_data;
  logic [4:0]  wr_addr;
  logic [47:0] rsp;
  logic [12:0] wq[$];
  int          errors = 0;
  int          check_count = 0;
  localparam logic [7:0] INS = 8'hB4;

  dcsp_top dcsp_top_i (
    .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .chain_select(chain_select),
    .check_code_enable_pin(check_code_enable_pin), .fault_clear_on_access(fault_clear_on_access),
    .input_state_bits(input_state_bits), .fault_event(fault_event),
    .clock_count_error_clr(clock_count_error_clr), .clock_count_error(clock_count_error),
    .fault_summary_bits(fault_summary_bits), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data)
  );
  dcsp_host_model dcsp_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_o), .sdo_oe(sdo_oe_o));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Every write taken downstream, in order
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_addr, wr_data});
  end
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Top two bits sent as ones: they must not matter
  function automatic logic [15:0] cmd(input logic wr, input logic [4:0] a, input logic [7:0] d);
    return {2'b11, a, wr, d};
  endfunction
  // One frame, then a gap long enough for the core to build the next answer
  task automatic xfer(input int n, input logic [47:0] c);
    dcsp_host_model_i.frame(n, c, rsp);
    repeat (12) @(negedge core_clk);
  endtask
  task automatic pop_wr(input logic [12:0] exp);
    check("write", wq.size() > 0 ? wq.pop_front() : {13{1'bx}}, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #200us;
    errors++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    chain_select = 1'b1;
    check_code_enable_pin = 1'b0;
    fault_clear_on_access = 1'b0;
    input_state_bits = INS;
    fault_event = 8'h00;
    clock_count_error_clr = 1'b0;
    wr_ready = 1'b1;
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    repeat (12) @(negedge core_clk);
    xfer(16, cmd(1, 5'h05, 8'hA5));
    check("resp", rsp, {INS, 8'h60});
    pop_wr({5'h05, 8'hA5});
    xfer(16, cmd(0, 5'h05, 8'h00));
    check("resp", rsp, {INS, 8'h60});
    check("queue", wq.size(), 0);
    xfer(16, cmd(1, 5'h07, 8'h3C));
    check("resp", rsp, {INS, 8'hA5});
    pop_wr({5'h07, 8'h3C});
    xfer(16, cmd(0, 5'h07, 8'h00));
    check("resp", rsp, {INS, 8'h60});
    // Latch one fault, then read it back and access around it
    fault_event = 8'h08;
    repeat (2) @(negedge core_clk);
    fault_event = 8'h00;
    repeat (4) @(negedge core_clk);
    check("faults", fault_summary_bits, 8'h68);
    xfer(16, cmd(0, 5'h01, 8'h00));
    check("resp", rsp, {INS, 8'h3C});
    xfer(16, cmd(0, 5'h05, 8'h00));
    check("resp", rsp, {INS, 8'h68});
    fault_clear_on_access = 1'b1;
    xfer(16, cmd(0, 5'h01, 8'h00));
    check("resp", rsp, {INS, 8'hA5});
    // Stall the write stream so both buffer entries fill
    fault_clear_on_access = 1'b0;
    wr_ready = 1'b0;
    xfer(16, cmd(1, 5'h09, 8'h11));
    check("resp", rsp, {INS, 8'h68});
    xfer(16, cmd(1, 5'h09, 8'h22));
    check("resp", rsp, {INS, 8'h68});
    check("queue", wq.size(), 0);
    wr_ready = 1'b1;
    repeat (4) @(negedge core_clk);
    pop_wr({5'h09, 8'h11});
    pop_wr({5'h09, 8'h22});
    check("faults", fault_summary_bits, 8'h68);
    // Two shares: downstream command first, passed out one share late
    xfer(32, {cmd(1, 5'h03, 8'h5A), cmd(1, 5'h09, 8'h77)});
    check("resp", rsp, {INS, 8'h68, cmd(1, 5'h03, 8'h5A)});
    pop_wr({5'h09, 8'h77});
    check("queue", wq.size(), 0);
    check_code_enable_pin = 1'b1;
    xfer(24, {cmd(1, 5'h06, 8'h42), 8'h00});
    check("resp", rsp, {INS, 8'h68, 8'h00});
    pop_wr({5'h06, 8'h42});
    xfer(16, cmd(1, 5'h04, 8'h99));
    check("resp", rsp, {INS, 8'h68});
    check("count error", clock_count_error, 1'b1);
    check("queue", wq.size(), 0);
    clock_count_error_clr = 1'b1;
    repeat (2) @(negedge core_clk);
    clock_count_error_clr = 1'b0;
    repeat (3) @(negedge core_clk);
    check("count error", clock_count_error, 1'b0);
    // Chained mode off: nothing executes
    check_code_enable_pin = 1'b0;
    chain_select = 1'b0;
    repeat (4) @(negedge core_clk);
    xfer(16, cmd(1, 5'h04, 8'h99));
    check("queue", wq.size(), 0);
    chain_select = 1'b1;
    // Second reset in mid-run
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    check("faults", fault_summary_bits, 8'h60);
    check("count error", clock_count_error, 1'b0);
    tally_and_finish();
  end
endmodule
